// ===== common/clr_pkg.sv
/*
 * Constants for the clip and current-limit reporting register bank.
 * Assumes a byte-wide register port decoded by the serial host interface.
 */
package clr_pkg;
   localparam logic [7:0] CLR_OFS_MODE_CTRL   = 8'h00;
   localparam logic [7:0] CLR_OFS_STATE_CTRL  = 8'h04;
   localparam logic [7:0] CLR_OFS_MISC3       = 8'h21;
   localparam logic [7:0] CLR_OFS_CLIP_CTRL   = 8'h22;
   localparam logic [7:0] CLR_OFS_CLIP_WIN    = 8'h23;
   localparam logic [7:0] CLR_OFS_CLIP_STAT   = 8'h24;
   localparam logic [7:0] CLR_OFS_ILIM_STAT   = 8'h25;
   localparam logic [7:0] CLR_OFS_POL_HPF     = 8'h26;
   localparam logic [7:0] CLR_RST_CLIP_CTRL   = 8'h01;
   localparam logic [7:0] CLR_RST_CLIP_WIN    = 8'h14;
   localparam logic [7:0] CLR_RST_POL_HPF     = 8'h40;
   localparam logic [7:0] CLR_RST_ZERO        = 8'h00;
   localparam logic [7:0] CLR_WIN_MAX         = 8'h14;
   localparam int         CLR_BIT_DET_EN      = 0;
   localparam int         CLR_BIT_NOLATCH     = 1;
   localparam int         CLR_BIT_PIN_SPLIT   = 2;
   localparam int         CLR_BIT_PHASE_FLIP  = 3;
   localparam int         CLR_BIT_CLEAR       = 7;
   localparam int         CLR_NCH             = 4;
   localparam int         CLR_FSW_SEL_W       = 3;
   localparam logic [2:0] CLR_FSW_38FS        = 3'h0;
   localparam logic [2:0] CLR_FSW_44FS        = 3'h1;
   localparam logic [2:0] CLR_FSW_48FS        = 3'h2;
   localparam logic [2:0] CLR_FSW_8FS         = 3'h3;
   localparam logic [2:0] CLR_FSW_10FS        = 3'h4;
   typedef enum logic [2:0] {
      CLR_ST_STANDBY = 3'h1,
      CLR_ST_MUTE    = 3'h2,
      CLR_ST_PLAY    = 3'h4
   } clr_state_t;
endpackage

// ===== hw/clr_chan_clip.sv
/*
 * Per-channel clip window counter and sticky flag.
 * Assumes full-duty and PWM cycle strobes already in the clk domain.
 */
module clr_chan_clip (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       det_en,
   input  wire logic [7:0] win_len,
   input  wire logic       pwm_tick,
   input  wire logic       full_duty,
   input  wire logic       clear,
   output logic            clip_live,
   output logic            clip_flag
);
   logic [7:0] run_r;

   // Counts consecutive full-duty cycles; any partial cycle restarts it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 8'h00;
      end else if (!det_en || (pwm_tick && !full_duty)) begin
         run_r <= 8'h00;
      end else if (pwm_tick && run_r != 8'hFF) begin
         run_r <= run_r + 8'h01;
      end
   end

   assign clip_live = det_en && (run_r >= win_len);

   // A new clip wins over a simultaneous clear.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clip_flag <= 1'b0;
      end else if (clip_live) begin
         clip_flag <= 1'b1;
      end else if (clear) begin
         clip_flag <= 1'b0;
      end
   end
endmodule

// ===== hw/clr_sync2.sv
/*
 * Two-flop synchroniser for a bus of pin levels.
 * Assumes the inputs are quasi-static relative to clk.
 */
module clr_sync2 #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         q    <= s1_r;
      end
   end
endmodule

// ===== hw/clr_top.sv
/*
 * Clip and current-limit reporting register bank of a four-channel amplifier.
 * Assumes a byte register port from the serial host slave, and PWM events
 * on clk; current-limit events arrive from pins and are synchronised here.
 */
module clr_top (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   output logic      [7:0]          reg_rdata,
   input  wire logic                pwm_tick,
   input  wire logic [3:0]          full_duty,
   input  wire logic [3:0]          current_cap_pin,
   input  wire logic [1:0]          bridge_pair_req,
   output logic                     alert_n,
   output logic                     error_n,
   output logic                     pair_fault,
   output logic                     bit_clock_phase_flip,
   output logic      [2:0]          highpass_cutoff_select,
   output logic      [2:0]          fsw_select,
   output logic      [3:0]          line_driver_mode,
   output logic      [1:0]          parallel_bridge_mode,
   output logic      [1:0]          diag_unit_pair
);
   logic [7:0]        clip_ctrl_r;
   logic [7:0]        clip_win_r;
   logic [7:0]        pol_hpf_r;
   logic [7:0]        mode_ctrl_r;
   logic [7:0]        state_ctrl_r;
   logic [3:0]        cap_flag_r;
   logic [3:0]        pin_hold_r;
   logic [1:0]        pbm_r;
   logic              pair_fault_r;
   logic [3:0]        cap_sync;
   logic [3:0]        clip_live;
   logic [3:0]        clip_flag;
   logic [3:0]        pin_src;
   logic              clear_fault;
   logic              in_standby;
   logic              clip_en;
   logic [7:0]        win_eff;

   assign clear_fault = reg_wr && reg_addr == clr_pkg::CLR_OFS_MISC3
                        && reg_wdata[clr_pkg::CLR_BIT_CLEAR];
   assign clip_en     = clip_ctrl_r[clr_pkg::CLR_BIT_DET_EN];
   // Out-of-range windows are clamped so a clip can still be reported.
   assign win_eff     = (clip_win_r > clr_pkg::CLR_WIN_MAX) ?
                        clr_pkg::CLR_WIN_MAX : clip_win_r;
   assign in_standby  = state_ctrl_r[2:0] == 3'(clr_pkg::CLR_ST_STANDBY);

   clr_sync2 #(
      .W (clr_pkg::CLR_NCH)
   ) u_cap_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (current_cap_pin),
      .q      (cap_sync)
   );

   genvar g;
   generate
      for (g = 0; g < clr_pkg::CLR_NCH; g++) begin : g_ch
         clr_chan_clip u_clip (
            .clk       (clk),
            .arst_n    (arst_n),
            .det_en    (clip_en),
            .win_len   (win_eff),
            .pwm_tick  (pwm_tick),
            .full_duty (full_duty[g]),
            .clear     (clear_fault),
            .clip_live (clip_live[g]),
            .clip_flag (clip_flag[g])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clip_ctrl_r <= clr_pkg::CLR_RST_CLIP_CTRL;
         clip_win_r  <= clr_pkg::CLR_RST_CLIP_WIN;
         pol_hpf_r   <= clr_pkg::CLR_RST_POL_HPF;
         mode_ctrl_r <= clr_pkg::CLR_RST_ZERO;
         state_ctrl_r <= 8'(clr_pkg::CLR_ST_STANDBY);
      end else if (reg_wr) begin
         case (reg_addr)
            clr_pkg::CLR_OFS_CLIP_CTRL:  clip_ctrl_r <= {5'h00, reg_wdata[2:0]};
            clr_pkg::CLR_OFS_CLIP_WIN:   clip_win_r  <= reg_wdata;
            clr_pkg::CLR_OFS_POL_HPF:    pol_hpf_r   <= reg_wdata;
            clr_pkg::CLR_OFS_MODE_CTRL:  mode_ctrl_r <= reg_wdata;
            clr_pkg::CLR_OFS_STATE_CTRL: state_ctrl_r <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Bridge pairing only latches in standby, so it never changes mid-play.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pbm_r <= 2'h0;
      end else if (in_standby) begin
         pbm_r <= bridge_pair_req;
      end
   end

   // Pair fault: both channels of a pair must share their 2-bit mode_ctrl_r field.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pair_fault_r <= 1'b0;
      end else if ((pbm_r[0] && mode_ctrl_r[1:0] != mode_ctrl_r[3:2]) ||
                   (pbm_r[1] && mode_ctrl_r[5:4] != mode_ctrl_r[7:6])) begin
         pair_fault_r <= 1'b1;
      end else if (clear_fault) begin
         pair_fault_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_flag_r <= 4'h0;
      end else begin
         cap_flag_r <= cap_sync | (clear_fault ? 4'h0 : cap_flag_r);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_hold_r <= 4'h0;
      end else begin
         pin_hold_r <= clip_live | (clear_fault ? 4'h0 : pin_hold_r);
      end
   end

   assign pin_src = clip_ctrl_r[clr_pkg::CLR_BIT_NOLATCH] ?
                    clip_live : pin_hold_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alert_n <= 1'b1;
         error_n <= 1'b1;
      end else if (clip_ctrl_r[clr_pkg::CLR_BIT_PIN_SPLIT]) begin
         alert_n <= ~|pin_src[1:0];
         error_n <= ~(|pin_src[3:2] | pair_fault_r);
      end else begin
         alert_n <= ~|pin_src;
         error_n <= ~pair_fault_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            clr_pkg::CLR_OFS_CLIP_CTRL:  reg_rdata <= clip_ctrl_r;
            clr_pkg::CLR_OFS_CLIP_WIN:   reg_rdata <= clip_win_r;
            clr_pkg::CLR_OFS_CLIP_STAT:  reg_rdata <= {4'h0, clip_flag};
            clr_pkg::CLR_OFS_ILIM_STAT:  reg_rdata <= {4'h0, cap_flag_r};
            clr_pkg::CLR_OFS_POL_HPF:    reg_rdata <= pol_hpf_r;
            clr_pkg::CLR_OFS_MODE_CTRL:  reg_rdata <= mode_ctrl_r;
            clr_pkg::CLR_OFS_STATE_CTRL: reg_rdata <= state_ctrl_r;
            default:                     reg_rdata <= 8'h00;
         endcase
      end
   end

   assign pair_fault             = pair_fault_r;
   assign bit_clock_phase_flip   = pol_hpf_r[clr_pkg::CLR_BIT_PHASE_FLIP];
   assign highpass_cutoff_select = pol_hpf_r[2:0];
   // Codes up to the 10x rate pass through; codes above it select the 44x rate.
   assign fsw_select  = (state_ctrl_r[7:5] > clr_pkg::CLR_FSW_10FS) ?
                        clr_pkg::CLR_FSW_44FS : state_ctrl_r[7:5];
   assign line_driver_mode       = {mode_ctrl_r[7], mode_ctrl_r[5],
                                    mode_ctrl_r[3], mode_ctrl_r[1]};
   assign parallel_bridge_mode   = pbm_r;
   assign diag_unit_pair         = pbm_r;

   property p_alert_follow;
      @(posedge clk) disable iff (!arst_n)
      ((|clip_live[1:0]) && clip_ctrl_r[1]) |=> !alert_n;
   endproperty
   a_alert_follow: assert property (p_alert_follow)
      else $error("alert not raised by live clip");

   // Latched mode needs one edge to fill the hold register first.
   sequence s_late_clip;
      (clip_ctrl_r[2] && !clip_ctrl_r[1] && (|clip_live[3:2]))
      ##1 (clip_ctrl_r[2] && !clip_ctrl_r[1]);
   endsequence

   property p_split_error;
      @(posedge clk) disable iff (!arst_n)
      s_late_clip |=> !error_n;
   endproperty
   a_split_error: assert property (p_split_error)
      else $error("error pin missed a late channel clip");

   property p_error_clean;
      @(posedge clk) disable iff (!arst_n)
      (!clip_ctrl_r[2] && !pair_fault_r) |=> error_n;
   endproperty
   a_error_clean: assert property (p_error_clean)
      else $error("error pin low without split or fault");

   property p_hold;
      @(posedge clk) disable iff (!arst_n)
      (!clip_ctrl_r[1] && $fell(|clip_live[1:0]) && !clear_fault
       && $stable(clip_ctrl_r)) |=> !alert_n;
   endproperty
   a_hold: assert property (p_hold)
      else $error("latched clip indication dropped");

   property p_follow_idle;
      @(posedge clk) disable iff (!arst_n)
      (clip_ctrl_r[1] && clip_live == 4'h0) |=> alert_n;
   endproperty
   a_follow_idle: assert property (p_follow_idle)
      else $error("alert held although latching is off");

   property p_disable;
      @(posedge clk) disable iff (!arst_n)
      (!clip_en && clip_flag == 4'h0) |=> clip_flag == 4'h0;
   endproperty
   a_disable: assert property (p_disable)
      else $error("clip seen while detection off");

   property p_status;
      @(posedge clk) disable iff (!arst_n)
      clip_live[2] |=> clip_flag[2];
   endproperty
   a_status: assert property (p_status)
      else $error("clip status not set");

   property p_sticky;
      @(posedge clk) disable iff (!arst_n)
      (clip_flag[0] && !clear_fault) |=> clip_flag[0];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("clip status dropped without a clear");

   // The pin passes two flops before the flag can take it.
   sequence s_cap_seen;
      current_cap_pin[1] ##2 1'b1;
   endsequence

   property p_cap;
      @(posedge clk) disable iff (!arst_n)
      s_cap_seen |=> cap_flag_r[1];
   endproperty
   a_cap: assert property (p_cap)
      else $error("current cap flag missed");

   property p_pbm_standby;
      @(posedge clk) disable iff (!arst_n)
      !in_standby |=> $stable(pbm_r);
   endproperty
   a_pbm_standby: assert property (p_pbm_standby)
      else $error("bridge mode changed outside standby");

   property p_standby_take;
      @(posedge clk) disable iff (!arst_n)
      in_standby |=> pbm_r == $past(bridge_pair_req);
   endproperty
   a_standby_take: assert property (p_standby_take)
      else $error("bridge request not taken in standby");

   property p_pair;
      @(posedge clk) disable iff (!arst_n)
      (pbm_r[0] && mode_ctrl_r[1:0] != mode_ctrl_r[3:2]) |=> pair_fault;
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair mismatch not flagged");

   property p_fault_pin;
      @(posedge clk) disable iff (!arst_n)
      pair_fault_r |=> !error_n;
   endproperty
   a_fault_pin: assert property (p_fault_pin)
      else $error("pair fault not shown on error pin");

   property p_clear_status;
      @(posedge clk) disable iff (!arst_n)
      (clear_fault && clip_live == 4'h0) |=> clip_flag == 4'h0;
   endproperty
   a_clear_status: assert property (p_clear_status)
      else $error("clip status survived a clear");

   property p_clear_cap;
      @(posedge clk) disable iff (!arst_n)
      (clear_fault && cap_sync == 4'h0) |=> cap_flag_r == 4'h0;
   endproperty
   a_clear_cap: assert property (p_clear_cap)
      else $error("current cap status survived a clear");

   property p_pair_clear;
      @(posedge clk) disable iff (!arst_n)
      (clear_fault && mode_ctrl_r == 8'h00) |=> !pair_fault;
   endproperty
   a_pair_clear: assert property (p_pair_clear)
      else $error("pair fault survived a clear");
endmodule

// ===== verif/clr_host_model.sv
/*
 * Host model: byte write and read cycles on the register port.
 * Assumes one calling process and the edge plus 1 ns drive point.
 */
module clr_host_model (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Idle data is inverted so no stale byte can pass for a new one.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench for the clip and current-limit register bank.
 * Assumes the host model above and bench-driven PWM and pin events.
 */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk, arst_n, reg_wr, reg_rd, pwm_tick;
   logic       alert_n, error_n, pair_fault, flip;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] full_duty, cap_pin, ldm;
   logic [2:0] hpf, fsw;
   logic [1:0] pair_req, pbm, dup;
   int         errors, compares;
   clr_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   clr_top u_clr_top (
      .clk(clk),
      .arst_n(arst_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .pwm_tick(pwm_tick),
      .full_duty(full_duty),
      .current_cap_pin(cap_pin),
      .bridge_pair_req(pair_req),
      .alert_n(alert_n),
      .error_n(error_n),
      .pair_fault(pair_fault),
      .bit_clock_phase_flip(flip),
      .highpass_cutoff_select(hpf),
      .fsw_select(fsw),
      .line_driver_mode(ldm),
      .parallel_bridge_mode(pbm),
      .diag_unit_pair(dup)
   );
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [7:0] pins();
      return {5'h00, alert_n, error_n, pair_fault};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   // Each tick is followed by an idle cycle, then the pins settle.
   task automatic ticks(input int n, input logic [3:0] fd);
      full_duty = fd;
      repeat (n) begin
         pwm_tick = 1'b1;
         cyc(1);
         pwm_tick = 1'b0;
         cyc(1);
      end
      cyc(3);
   endtask
   task automatic t_reset;
      chk(pins(), 8'h06);
      chk_reg(8'h22, 8'h01);
      chk_reg(8'h23, 8'h14);
      chk_reg(8'h24, 8'h00);
      chk_reg(8'h25, 8'h00);
      chk_reg(8'h26, 8'h40);
      u_host.wr(8'h7F, 8'h5A);
      chk_reg(8'h7F, 8'h00);
      u_host.wr(8'h24, 8'hFF);
      chk_reg(8'h24, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_window;
      u_host.wr(8'h23, 8'hFF);
      ticks(19, 4'h1);
      chk_reg(8'h24, 8'h00);
      ticks(1, 4'h1);
      chk_reg(8'h24, 8'h01);
      chk(pins(), 8'h02);
      ticks(1, 4'h0);
      u_host.wr(8'h21, 8'h80);
      u_host.wr(8'h23, 8'h03);
      ticks(2, 4'h1);
      chk_reg(8'h24, 8'h00);
      ticks(1, 4'h1);
      chk_reg(8'h24, 8'h01);
      chk(pins(), 8'h02);
      ticks(1, 4'h0);
      chk(pins(), 8'h02);
      u_host.wr(8'h21, 8'h80);
      chk_reg(8'h24, 8'h00);
      chk(pins(), 8'h06);
      $display("t_window done");
   endtask
   task automatic t_split;
      ticks(3, 4'h8);
      chk(pins(), 8'h02);
      ticks(1, 4'h0);
      u_host.wr(8'h21, 8'h80);
      u_host.wr(8'h22, 8'h05);
      ticks(3, 4'h4);
      chk(pins(), 8'h04);
      chk_reg(8'h24, 8'h04);
      ticks(3, 4'h3);
      chk(pins(), 8'h00);
      ticks(1, 4'h0);
      u_host.wr(8'h21, 8'h80);
      $display("t_split done");
   endtask
   task automatic t_modes;
      u_host.wr(8'h22, 8'h03);
      ticks(3, 4'h2);
      chk(pins(), 8'h02);
      ticks(1, 4'h0);
      chk(pins(), 8'h06);
      u_host.wr(8'h21, 8'h80);
      u_host.wr(8'h22, 8'h00);
      ticks(4, 4'hF);
      chk_reg(8'h24, 8'h00);
      chk(pins(), 8'h06);
      ticks(1, 4'h0);
      cap_pin = 4'hA;
      cyc(4);
      cap_pin = 4'h0;
      cyc(4);
      chk_reg(8'h25, 8'h0A);
      u_host.wr(8'h21, 8'h80);
      chk_reg(8'h25, 8'h00);
      $display("t_modes done");
   endtask
   task automatic t_pol;
      for (int i = 0; i < 16; i++) begin
         u_host.wr(8'h26, {4'h4, i[3:0]});
         chk({4'h0, flip, hpf}, {4'h0, i[3:0]});
         chk_reg(8'h26, {4'h4, i[3:0]});
      end
      u_host.wr(8'h26, 8'h40);
      $display("t_pol done");
   endtask
   // The host pairs channels while still in standby, then goes to play.
   task automatic t_bridge;
      pair_req = 2'b01;
      cyc(3);
      chk({6'h00, pbm}, 8'h01);
      chk({6'h00, dup}, 8'h01);
      u_host.wr(8'h00, 8'hAA);
      chk({4'h0, ldm}, 8'h0F);
      chk(pins(), 8'h06);
      u_host.wr(8'h00, 8'h02);
      cyc(2);
      chk(pins(), 8'h05);
      u_host.wr(8'h00, 8'h00);
      u_host.wr(8'h21, 8'h80);
      chk(pins(), 8'h06);
      for (int i = 0; i < 8; i++) begin
         u_host.wr(8'h04, {i[2:0], 5'h04});
         chk({5'h00, fsw}, (i > 4) ? 8'h01 : 8'(i));
      end
      pair_req = 2'b11;
      cyc(3);
      chk({6'h00, pbm}, 8'h01);
      u_host.wr(8'h04, 8'h01);
      cyc(3);
      chk({6'h00, pbm}, 8'h03);
      chk({6'h00, dup}, 8'h03);
      u_host.wr(8'h00, 8'h40);
      cyc(2);
      chk({4'h0, ldm}, 8'h00);
      chk(pins(), 8'h05);
      u_host.wr(8'h00, 8'h00);
      u_host.wr(8'h21, 8'h80);
      chk(pins(), 8'h06);
      $display("t_bridge done");
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      complete_run();
   end
   initial begin
      errors = 0;
      compares = 0;
      arst_n = 1'b0;
      pwm_tick = 1'b0;
      full_duty = 4'h0;
      cap_pin = 4'h0;
      pair_req = 2'b00;
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'b1;
      t_reset();
      t_window();
      t_split();
      t_modes();
      t_pol();
      t_bridge();
      complete_run();
   end
endmodule
